/* File: src/slot_fault_defines.svh */
// constants for the dual-slot power fault status block
// How it works
// [R01] bit 7 reads 1 while fault pin low
// [R02] bit 6 shows actual main power state
// [R03] bit 5 shows actual standby power state
// [R04] bits 4..0 overcurrent flags; 7..5 read-only
// [R05] status flags and fault bit reset to zero; bits 6 and 5 follow power state
// [R06] slot A status at command 04h
// [R07] slot B status at command 05h
// [R08] write one clears flag; interrupt drops once no flag is left
// [R09] reads and clears leave fault pin alone
// [R10] main fault latch released by main request low
// [R11] standby fault latch released by standby request low
// [R12] both latched needs both requests low
// [R13] serial control keeps fault bit and pin inactive
// [R14] host holds requests low under serial control
// [R15] control register bit1 main, bit0 standby enable
// [R16] mask bit 3: 0 enables, 1 disables interrupt
// [R17] overcurrent sets flag; interrupt while flag unmasked
// [R18] flags hold until written with one
`ifndef SLOT_FAULT_DEFINES_SVH
`define SLOT_FAULT_DEFINES_SVH
`define ADDR_CTRL_A      8'h02
`define ADDR_CTRL_B      8'h03
`define ADDR_STAT_A      8'h04
`define ADDR_STAT_B      8'h05
`define ADDR_COMMON      8'h06
`define STAT_RESET       8'h00
`define CTRL_RESET       8'h00
`define COMMON_RESET     8'h00
`define RDATA_IDLE       8'h00
`define BIT_FAULT        7
`define BIT_MAIN         6
`define BIT_STBY         5
`define BIT_STBY_OC      4
`define BIT_MASK         3
`define BIT_CTRL_MAIN    1
`define BIT_CTRL_STBY    0
`define OC_MSB           4
`define MAIN_OC_MASK     5'h0F
`define STBY_OC_MASK     5'h10
`endif

/* File: src/slot_fault_dev.sv */
// dual-slot power fault status device: status, control, common registers
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "slot_fault_defines.svh"
module slot_fault_dev
  import slot_fault_pkg::*;
#(
  parameter int SLOTS = 2
) (
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_b,
  // link to host
  slot_fault_if.device          lnk,
  // analog sensing, per slot: {standby, -12, +12, 5, 3}
  input  wire logic [4:0]       i_oc_a,
  input  wire logic [4:0]       i_oc_b,
  // actual output states from the power stage
  input  wire logic [SLOTS-1:0] i_main_on,
  input  wire logic [SLOTS-1:0] i_stby_on,
  // power-good levels shown in control registers
  input  wire logic [SLOTS-1:0] i_main_pg,
  input  wire logic [SLOTS-1:0] i_stby_pg,
  // power path enables
  output logic      [SLOTS-1:0] o_main_en,
  output logic      [SLOTS-1:0] o_stby_en
);
  oc_flags_t        oc_ff   [SLOTS];
  logic [SLOTS-1:0] main_latch_ff;
  logic [SLOTS-1:0] stby_latch_ff;
  logic [1:0]       ctrl_ff [SLOTS];
  logic             mask_ff;
  reg_byte_t        rdata_ff;
  logic [SLOTS-1:0] serial_ctrl;
  logic [SLOTS-1:0] fault_act;
  logic [SLOTS-1:0] flag_any;
  oc_flags_t        oc_in   [SLOTS];

  assign oc_in[0] = i_oc_a;
  assign oc_in[1] = i_oc_b;

  function automatic logic sel(input reg_byte_t a, input reg_byte_t b);
    sel = (a == b);
  endfunction : sel

  genvar s;
  generate
    for (s = 0; s < SLOTS; s++) begin : g_slot
      localparam reg_byte_t STAT_ADDR = `ADDR_STAT_A + 8'(s);
      localparam reg_byte_t CTRL_ADDR = `ADDR_CTRL_A + 8'(s);
      logic wr_stat;
      logic wr_ctrl;
      assign wr_stat = lnk.cmd_wr && sel(lnk.cmd_addr, STAT_ADDR); // R06 R07
      assign wr_ctrl = lnk.cmd_wr && sel(lnk.cmd_addr, CTRL_ADDR);
      // serial control is any software enable set for the slot
      assign serial_ctrl[s] = |ctrl_ff[s];
      assign flag_any[s]    = |oc_ff[s];

      // set wins over a clear in the same cycle
      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
          oc_ff[s] <= oc_flags_t'(`STAT_RESET); // R05
        end else begin
          oc_ff[s] <= (oc_ff[s] & ~(wr_stat ? lnk.cmd_wdata[`OC_MSB:0] : 5'h00)) // R08 R18
                      | oc_in[s]; // R17
        end
      end

      // fault pin latches: released only by the matching request going low
      // a fresh overcurrent wins over a release in the same cycle
      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
          main_latch_ff[s] <= 1'b0;
        end else if (|(oc_in[s] & `MAIN_OC_MASK) && !serial_ctrl[s]) begin
          main_latch_ff[s] <= 1'b1;
        end else if (!lnk.main_request_in[s]) begin
          main_latch_ff[s] <= 1'b0; // R10
        end
      end

      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
          stby_latch_ff[s] <= 1'b0;
        end else if (|(oc_in[s] & `STBY_OC_MASK) && !serial_ctrl[s]) begin
          stby_latch_ff[s] <= 1'b1;
        end else if (!lnk.standby_request_in[s]) begin
          stby_latch_ff[s] <= 1'b0; // R11
        end
      end
      // R09: register access never touches the latches
      assign fault_act[s] = (main_latch_ff[s] | stby_latch_ff[s]) & ~serial_ctrl[s]; // R12 R13
      assign lnk.fault_pin_n[s] = ~fault_act[s];

      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
          ctrl_ff[s] <= 2'(`CTRL_RESET);
        end else if (wr_ctrl) begin
          ctrl_ff[s] <= {lnk.cmd_wdata[`BIT_CTRL_MAIN], lnk.cmd_wdata[`BIT_CTRL_STBY]}; // R15
        end
      end
      // R14: host keeps requests low while software drives the slot
      assign o_main_en[s] = ctrl_ff[s][1] | lnk.main_request_in[s];
      assign o_stby_en[s] = ctrl_ff[s][0] | lnk.standby_request_in[s];
    end
  endgenerate

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      mask_ff <= 1'(`COMMON_RESET >> `BIT_MASK);
    end else if (lnk.cmd_wr && sel(lnk.cmd_addr, `ADDR_COMMON)) begin
      mask_ff <= lnk.cmd_wdata[`BIT_MASK];
    end
  end

  function automatic reg_byte_t stat_byte(input int i);
    reg_byte_t b;
    b = `STAT_RESET;
    b[`BIT_FAULT] = fault_act[i]; // R01
    b[`BIT_MAIN]  = i_main_on[i]; // R02
    b[`BIT_STBY]  = i_stby_on[i]; // R03
    b[`OC_MSB:0]  = oc_ff[i]; // R04
    return b;
  endfunction : stat_byte

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rdata_ff <= `RDATA_IDLE;
    end else if (lnk.cmd_rd) begin
      case (lnk.cmd_addr)
        `ADDR_STAT_A: rdata_ff <= stat_byte(0);
        `ADDR_STAT_B: rdata_ff <= stat_byte(1);
        `ADDR_CTRL_A: rdata_ff <= {i_stby_pg[0], i_main_pg[0], 4'h0, ctrl_ff[0]};
        `ADDR_CTRL_B: rdata_ff <= {i_stby_pg[1], i_main_pg[1], 4'h0, ctrl_ff[1]};
        `ADDR_COMMON: rdata_ff <= {4'h0, mask_ff, 3'h0};
        default:      rdata_ff <= `RDATA_IDLE;
      endcase
    end else begin
      // data stands for one cycle only, then the port idles at zero
      rdata_ff <= `RDATA_IDLE;
    end
  end
  assign lnk.cmd_rdata = rdata_ff;

  // interrupt is level, so clearing the last flag drops it at once
  assign lnk.irq_n = ~(|flag_any & ~mask_ff); // R16 R17
endmodule : slot_fault_dev

/* File: src/slot_fault_host.sv */
// host end: register port for software plus registered hot-plug requests, gated by serial mode
`timescale 1ns/1ps
`include "slot_fault_defines.svh"
module slot_fault_host
  import slot_fault_pkg::*;
#(
  parameter int SLOTS = 2
) (
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_b,
  // link to device
  slot_fault_if.host            lnk,
  // software register port, passed to the device
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  input  wire logic [7:0]       i_addr,
  input  wire logic [7:0]       i_wdata,
  output logic      [7:0]       o_rdata,
  output logic                  o_irq,
  // hot-plug requests per slot; serial mode forces requests low
  input  wire logic [SLOTS-1:0] i_main_req,
  input  wire logic [SLOTS-1:0] i_stby_req,
  input  wire logic [SLOTS-1:0] i_serial_mode,
  // fault seen on each slot pin
  output logic      [SLOTS-1:0] o_fault
);
  logic [SLOTS-1:0] main_ff;
  logic [SLOTS-1:0] stby_ff;

  assign lnk.cmd_wr    = i_wr;
  assign lnk.cmd_rd    = i_rd;
  assign lnk.cmd_addr  = i_addr;
  assign lnk.cmd_wdata = i_wdata;
  assign o_rdata       = lnk.cmd_rdata;
  assign o_irq         = ~lnk.irq_n;

  genvar s;
  generate
    for (s = 0; s < SLOTS; s++) begin : g_slot
      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
          main_ff[s] <= 1'b0;
          stby_ff[s] <= 1'b0;
        end else begin
          main_ff[s] <= i_main_req[s] & ~i_serial_mode[s]; // R14 R10
          stby_ff[s] <= i_stby_req[s] & ~i_serial_mode[s]; // R14 R11
        end
      end
      assign o_fault[s] = ~lnk.fault_pin_n[s];
    end
  endgenerate
  // dropping both requests clears a double latch
  assign lnk.main_request_in    = main_ff; // R12
  assign lnk.standby_request_in = stby_ff;
endmodule : slot_fault_host

/* File: src/slot_fault_if.sv */
// link between the fault status device and the hot-plug / management host
`timescale 1ns/1ps
interface slot_fault_if;
  import slot_fault_pkg::*;
  logic       cmd_wr;
  logic       cmd_rd;
  reg_byte_t  cmd_addr;
  reg_byte_t  cmd_wdata;
  reg_byte_t  cmd_rdata;
  logic [1:0] main_request_in;
  logic [1:0] standby_request_in;
  logic [1:0] fault_pin_n;
  logic       irq_n;
  modport device (
    input  cmd_wr, cmd_rd, cmd_addr, cmd_wdata, main_request_in, standby_request_in,
    output cmd_rdata, fault_pin_n, irq_n
  );
  modport host (
    output cmd_wr, cmd_rd, cmd_addr, cmd_wdata, main_request_in, standby_request_in,
    input  cmd_rdata, fault_pin_n, irq_n
  );
endinterface : slot_fault_if

/* File: src/slot_fault_pkg.sv */
// types shared by both ends of the slot fault status link
package slot_fault_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [4:0] oc_flags_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h1,
    HS_ON   = 3'h2,
    HS_DROP = 3'h4
  } hp_state_t;
endpackage : slot_fault_pkg

/* File: test/slot_fault_sva.sv */
// link checker for the slot fault status device and host
`timescale 1ns/1ps
module slot_fault_sva
  import slot_fault_pkg::*;
(
  // clock and reset
  input wire logic       i_ref_clk,
  input wire logic       i_rst_b,
  // link signals
  input wire logic       cmd_wr,
  input wire logic       cmd_rd,
  input wire reg_byte_t  cmd_addr,
  input wire reg_byte_t  cmd_wdata,
  input wire reg_byte_t  cmd_rdata,
  input wire logic [1:0] main_request_in,
  input wire logic [1:0] standby_request_in,
  input wire logic [1:0] fault_pin_n,
  input wire logic       irq_n
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  a_reset_quiet: assert property ($rose(i_rst_b) |-> fault_pin_n == 2'h3 && irq_n)
    else $error("pins active after reset");
  a_fault_bit_a: assert property (cmd_rd && cmd_addr == 8'h04 |=>
    cmd_rdata[7] == !$past(fault_pin_n[0])) else $error("slot a fault bit");
  a_fault_bit_b: assert property (cmd_rd && cmd_addr == 8'h05 |=>
    cmd_rdata[7] == !$past(fault_pin_n[1])) else $error("slot b fault bit");
  // only a request low or a control write may free a latched pin
  a_pin_holds: assert property (!fault_pin_n[0] && main_request_in[0] &&
    standby_request_in[0] && !(cmd_wr && cmd_addr == 8'h02) |=> !fault_pin_n[0])
    else $error("fault pin dropped");
  a_pin_release: assert property ($rose(fault_pin_n[0]) && $past(i_rst_b) |->
    !$past(main_request_in[0]) || !$past(standby_request_in[0]) || $past(cmd_wr))
    else $error("fault pin freed early");
  a_serial_quiet: assert property (cmd_wr && cmd_addr == 8'h02 &&
    cmd_wdata[1:0] != 2'h0 |=> fault_pin_n[0]) else $error("pin active in serial");
  a_mask_quiet: assert property (cmd_wr && cmd_addr == 8'h06 && cmd_wdata[3]
    |=> irq_n) else $error("irq while masked");
  a_unmapped_zero: assert property (cmd_rd && cmd_addr > 8'h06 |=>
    cmd_rdata == 8'h00) else $error("unmapped read not zero");
endmodule : slot_fault_sva

/* File: test/test_slot_fault_status.sv */
// bench joining host and device ends over the link
`timescale 1ns/1ps
module test_slot_fault_status;
  import slot_fault_pkg::*;
  typedef struct {reg_byte_t a; oc_flags_t oc; logic [1:0] on; reg_byte_t e;} row_t;
  logic       i_ref_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, o_irq;
  reg_byte_t  i_addr = 8'h00, i_wdata = 8'h00, o_rdata, d;
  logic [1:0] i_main_req = 2'h0, i_stby_req = 2'h0, i_serial_mode = 2'h0, o_fault;
  logic [1:0] i_main_on = 2'h0, i_stby_on = 2'h0, i_main_pg = 2'h0, i_stby_pg = 2'h0;
  oc_flags_t  i_oc_a = 5'h00, i_oc_b = 5'h00;
  logic [1:0] o_main_en, o_stby_en;
  int         err_count = 0, compares = 0, cyc = 0;
  row_t rows[7] = '{'{8'h04, 5'h01, 2'h2, 8'hC1}, '{8'h04, 5'h02, 2'h1, 8'hA2},
    '{8'h04, 5'h04, 2'h3, 8'hE4}, '{8'h04, 5'h08, 2'h0, 8'h88}, '{8'h04, 5'h10, 2'h0, 8'h90},
    '{8'h05, 5'h1F, 2'h3, 8'hFF}, '{8'h05, 5'h00, 2'h1, 8'h20}};
  slot_fault_if lnk();
  slot_fault_dev i_slot_fault_dev (.i_ref_clk, .i_rst_b, .lnk, .i_oc_a, .i_oc_b, .i_main_on,
    .i_stby_on, .i_main_pg, .i_stby_pg, .o_main_en, .o_stby_en);
  slot_fault_host i_slot_fault_host (.i_ref_clk, .i_rst_b, .lnk, .i_wr, .i_rd, .i_addr,
    .i_wdata, .o_rdata, .o_irq, .i_main_req, .i_stby_req, .i_serial_mode, .o_fault);
  slot_fault_sva chk_link (.i_ref_clk, .i_rst_b, .cmd_wr(lnk.cmd_wr), .cmd_rd(lnk.cmd_rd),
    .cmd_addr(lnk.cmd_addr), .cmd_wdata(lnk.cmd_wdata), .cmd_rdata(lnk.cmd_rdata),
    .main_request_in(lnk.main_request_in), .standby_request_in(lnk.standby_request_in),
    .fault_pin_n(lnk.fault_pin_n), .irq_n(lnk.irq_n));
  always #2.5 i_ref_clk = ~i_ref_clk;
  task automatic give_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input reg_byte_t seen, input reg_byte_t exp, input string nm);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : wt
  task automatic wr(input reg_byte_t a, input reg_byte_t v);
    wt(1);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    wt(1);
    i_wr <= 1'b0;
  endtask : wr
  // sampled mid-cycle so the answer has settled
  task automatic rd(input reg_byte_t a);
    wt(1);
    i_rd <= 1'b1;
    i_addr <= a;
    wt(1);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    d = o_rdata;
  endtask : rd
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    wt(10);
    i_rst_b <= 1'b1;
    foreach (rows[k]) begin
      wt(1);
      i_main_req <= 2'h3;
      i_stby_req <= 2'h3;
      i_main_on <= {2{rows[k].on[1]}};
      i_stby_on <= {2{rows[k].on[0]}};
      wt(2);
      if (rows[k].a[0]) i_oc_b <= rows[k].oc;
      else i_oc_a <= rows[k].oc;
      wt(1);
      i_oc_a <= 5'h00;
      i_oc_b <= 5'h00;
      rd(rows[k].a);
      chk(d, rows[k].e, "status");
      chk(8'(o_irq), 8'(rows[k].oc != 5'h00), "irq");
      wr(rows[k].a, 8'hFF);
      rd(rows[k].a);
      chk(d, rows[k].e & 8'hE0, "cleared");
      chk(8'(o_irq), 8'h00, "irq cleared");
      wt(1);
      i_main_req <= 2'h0;
      i_stby_req <= 2'h0;
      wt(3);
      chk(8'(o_fault), 8'h00, "released");
    end
    i_main_on <= 2'h0;
    i_stby_on <= 2'h0;
    i_main_req <= 2'h3;
    i_stby_req <= 2'h3;
    wt(3);
    i_oc_a <= 5'h11;
    wt(1);
    i_oc_a <= 5'h00;
    i_main_req <= 2'h0;
    wt(3);
    chk(8'(o_fault), 8'h01, "fault held");
    i_stby_req <= 2'h0;
    wt(3);
    chk(8'(o_fault), 8'h00, "fault freed");
    wr(8'h06, 8'h08);
    rd(8'h04);
    chk(d, 8'h11, "held flags");
    chk(8'(o_irq), 8'h00, "masked");
    wr(8'h06, 8'h00);
    wr(8'h04, 8'h01);
    rd(8'h04);
    chk(d, 8'h10, "one cleared");
    chk(8'(o_irq), 8'h01, "unmasked");
    wt(1);
    i_serial_mode <= 2'h1;
    i_main_pg <= 2'h1;
    wr(8'h02, 8'h03);
    i_oc_a <= 5'h01;
    wt(1);
    i_oc_a <= 5'h00;
    rd(8'h04);
    chk(d, 8'h11, "serial status");
    chk(8'(o_fault[0]), 8'h00, "serial pin");
    rd(8'h02);
    chk(d, 8'h43, "control a");
    chk(8'({o_main_en, o_stby_en}), 8'h05, "enables");
    rd(8'h07);
    chk(d, 8'h00, "unmapped");
    wt(1);
    i_rst_b <= 1'b0;
    wt(2);
    i_rst_b <= 1'b1;
    rd(8'h04);
    chk(d, 8'h00, "reset a");
    rd(8'h05);
    chk(d, 8'h00, "reset b");
    chk(8'({o_main_en, o_stby_en}), 8'h00, "reset enables");
    give_verdict();
  end
endmodule : test_slot_fault_status
